// File: rtl/pab_core.v
// program address banking: 16-bit ROM address generator with apb access
// assumes the rom answers in the same cycle as romAddr is presented
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "pab_regs.vh"

// How it works
// - 64K-word ROM, 13-bit pointer, eight banks
// - jump/call: bank bits 7:5 plus 13 code bits
// - full address latched at jump; set bank first
// - interrupts always vector into bank 0
// - interrupt pushes 16 bits; return restores bank
// - reset starts fetch at address zero
// - external or serial interrupt vectors to 004H
// - timer 0/1 overflow vectors 008H/00CH
// - timer 2/3 overflow vectors 010H/014H
// - converter buffer empty vectors to 018H
// - bank field 000 to 111 selects bank
// - table reads: low byte out, high latched
// - table high latch is read only
// - table pointer in two writable bytes
// - table reads take two cycles
// - pointer low-byte write jumps within page
// - met skip discards prefetch, lands plus two
// - full stack holds vector until return

module pab_core (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [5:0] irqReq,
  input wire [5:0] irqEnable,
  input wire [15:0] romData,
  output reg [15:0] romAddr,
  output reg vectorTaken,
  output reg tableWrite,
  output reg [7:0] tableAddr,
  output reg [7:0] tableData
);
  reg [7:0] bank_reg;
  reg [7:0] tpLo_reg;
  reg [7:0] tpHi_reg;
  reg [7:0] tbh_reg;
  reg [5:0] pend_reg;
  reg [15:0] pc_reg;
  reg [15:0] pc_next;
  reg [12:0] target_reg;
  reg [7:0] dAddr_reg;
  reg [7:0] dData_reg;
  reg [15:0] tblAddr_reg;
  reg [1:0] state_reg;
  reg busy_reg;
  reg tblRd_reg;
  reg [5:0] reqPrev_reg;
  reg [31:0] rdMux;
  reg [`PAB_CMD_W-1:0] cmd;
  reg [15:0] vecAddr;
  reg vecGo;
  reg push;
  reg pop;
  integer k;

  localparam ST_RUN = 2'b00;
  localparam ST_DUMMY = 2'b01;
  localparam ST_TABLE = 2'b10;

  wire [15:0] stackTop;
  wire stackFull;
  wire stackEmpty;
  wire [7:0] addrIdx = paddr[9:2];
  wire setup = psel && !penable;
  wire wrStb = psel && penable && pwrite && pready;
  wire cmdStb = wrStb && (addrIdx == `PAB_IDX_CTRL) && (state_reg == ST_RUN);
  wire [5:0] reqNow = irqReq & irqEnable;
  // flags set on a rising request, so a held level is serviced once
  wire [5:0] reqRise = reqNow & ~reqPrev_reg;
  wire [5:0] pendNow = pend_reg | reqRise;

  pab_ret_stack u_stack (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .push(push),
    .pop(pop),
    .pushAddr(pc_reg),
    .topAddr(stackTop),
    .full(stackFull),
    .empty(stackEmpty)
  );

  // lowest vector address first, the rest stay pending
  always @* begin
    vecAddr = `PAB_VEC_RESET;
    vecGo = 1'b0;
    for (k = `PAB_NUM_IRQ - 1; k >= 0; k = k - 1) begin
      if (pendNow[k]) begin
        vecGo = 1'b1;
        vecAddr = `PAB_VEC_EXT + {11'h000, k[2:0], 2'b00};
      end
    end
  end

  always @* begin
    cmd = cmdStb ? pwdata[`PAB_CMD_W-1:0] : `PAB_CMD_NONE;
    pc_next = pc_reg;
    push = 1'b0;
    pop = 1'b0;
    case (cmd)
      `PAB_CMD_STEP: pc_next = {pc_reg[15:13], pc_reg[12:0] + 13'h0001};
      `PAB_CMD_JUMP: begin
        // bank comes from the selector as it stands now
        pc_next = {bank_reg[`PAB_BANK_MSB:`PAB_BANK_LSB], target_reg};
      end
      `PAB_CMD_CALL: begin
        pc_next = {bank_reg[`PAB_BANK_MSB:`PAB_BANK_LSB], target_reg};
        push = 1'b1;
      end
      `PAB_CMD_RET, `PAB_CMD_INTERRUPT_RETURN: begin
        pc_next = stackTop;
        pop = 1'b1;
      end
      `PAB_CMD_SKIP: pc_next = {pc_reg[15:13], pc_reg[12:0] + 13'h0002};
      `PAB_CMD_PCL: pc_next = {pc_reg[15:8], pwdata[15:8]};
      default: pc_next = pc_reg;
    endcase
    // vectoring only between commands; a full stack withholds it
    if (state_reg == ST_RUN && !cmdStb && vecGo && !stackFull) begin
      pc_next = vecAddr;
      push = 1'b1;
    end
  end

  always @* begin
    case (addrIdx)
      `PAB_IDX_BANK: rdMux = {24'h000000, bank_reg};
      `PAB_IDX_TPLO: rdMux = {24'h000000, tpLo_reg};
      `PAB_IDX_TBHL: rdMux = {24'h000000, tbh_reg};
      `PAB_IDX_TPHI: rdMux = {24'h000000, tpHi_reg};
      `PAB_IDX_CTRL: rdMux = 32'h00000000;
      `PAB_IDX_STAT: rdMux = {27'h0000000, stackEmpty, stackFull, busy_reg,
                              state_reg};
      `PAB_IDX_PEND: rdMux = {26'h0000000, pend_reg};
      `PAB_IDX_PTRL: rdMux = {16'h0000, pc_reg};
      `PAB_IDX_PTRH: rdMux = {19'h00000, target_reg};
      `PAB_IDX_DADR: rdMux = {24'h000000, dAddr_reg};
      `PAB_IDX_DDAT: rdMux = {24'h000000, dData_reg};
      default: rdMux = 32'h00000000;
    endcase
  end

  // apb slave: no wait states, unmapped addresses flag an error
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rdMux;
        case (addrIdx)
          `PAB_IDX_BANK, `PAB_IDX_TPLO, `PAB_IDX_TPHI, `PAB_IDX_CTRL,
          `PAB_IDX_STAT, `PAB_IDX_PEND, `PAB_IDX_PTRL, `PAB_IDX_PTRH,
          `PAB_IDX_DADR, `PAB_IDX_DDAT: pslverr <= 1'b0;
          `PAB_IDX_TBHL: pslverr <= pwrite;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_reg <= `PAB_BANK_RST;
      tpLo_reg <= 8'h00;
      tpHi_reg <= 8'h00;
      target_reg <= 13'h0000;
      dAddr_reg <= 8'h00;
    end else if (wrStb) begin
      case (addrIdx)
        `PAB_IDX_BANK: bank_reg <= pwdata[7:0];
        `PAB_IDX_TPLO: tpLo_reg <= pwdata[7:0];
        `PAB_IDX_TPHI: tpHi_reg <= pwdata[7:0];
        `PAB_IDX_PTRH: target_reg <= pwdata[12:0];
        `PAB_IDX_DADR: dAddr_reg <= pwdata[7:0];
        default: bank_reg <= bank_reg;
      endcase
    end
  end

  // pending flags: a new request wins over the clear on vectoring
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= 6'h00;
      reqPrev_reg <= 6'h00;
    end else begin
      reqPrev_reg <= reqNow;
      if (state_reg == ST_RUN && !cmdStb && vecGo && !stackFull) begin
        // a fresh edge on an already set flag survives its clear
        pend_reg <= (pendNow & ~(pendNow & ~(pendNow - 6'h01)))
                    | (reqRise & pend_reg);
      end else begin
        pend_reg <= pendNow;
      end
    end
  end

  // sequencer: control transfer, skip and table reads take a dummy cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= `PAB_VEC_RESET;
      romAddr <= `PAB_VEC_RESET;
      state_reg <= ST_RUN;
      busy_reg <= 1'b0;
      vectorTaken <= 1'b0;
      tableWrite <= 1'b0;
      tableAddr <= 8'h00;
      tableData <= 8'h00;
      tbh_reg <= 8'h00;
      dData_reg <= 8'h00;
      tblAddr_reg <= 16'h0000;
      tblRd_reg <= 1'b0;
    end else begin
      vectorTaken <= 1'b0;
      tableWrite <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          pc_reg <= pc_next;
          romAddr <= pc_next;
          if (push && !cmdStb) begin
            vectorTaken <= 1'b1;
          end
          if (cmd == `PAB_CMD_TRDC) begin
            tblAddr_reg <= {tpHi_reg, tpLo_reg};
            state_reg <= ST_TABLE;
            busy_reg <= 1'b1;
          end else if (cmd == `PAB_CMD_TRDL) begin
            tblAddr_reg <= {`PAB_LAST_PAGE, tpLo_reg};
            state_reg <= ST_TABLE;
            busy_reg <= 1'b1;
          end else if (pc_next != pc_reg && cmd != `PAB_CMD_STEP) begin
            state_reg <= ST_DUMMY;
            busy_reg <= 1'b1;
          end
        end
        ST_TABLE: begin
          // first cycle of the read: rom gets the table address for the next cycle
          romAddr <= tblAddr_reg;
          tblRd_reg <= 1'b1;
          state_reg <= ST_DUMMY;
        end
        ST_DUMMY: begin
          // own flag: a table word at the pointer's address still lands
          if (tblRd_reg) begin
            tableWrite <= 1'b1;
            tableAddr <= dAddr_reg;
            tableData <= romData[7:0];
            dData_reg <= romData[7:0];
            tbh_reg <= romData[15:8];
          end
          romAddr <= pc_reg;
          state_reg <= ST_RUN;
          busy_reg <= 1'b0;
          tblRd_reg <= 1'b0;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end
endmodule

// File: common/pab_regs.vh
// program address banking: register offsets, field positions, vectors
// included by the banking core and its stack; definitions only
`ifndef PAB_REGS_VH
`define PAB_REGS_VH

// register indices; the apb byte address is four times the index
`define PAB_IDX_BANK 8'h04
`define PAB_IDX_TPLO 8'h07
`define PAB_IDX_TBHL 8'h08
`define PAB_IDX_TPHI 8'h1F
`define PAB_IDX_CTRL 8'h40
`define PAB_IDX_STAT 8'h41
`define PAB_IDX_PEND 8'h42
`define PAB_IDX_PTRL 8'h43
`define PAB_IDX_PTRH 8'h44
`define PAB_IDX_DADR 8'h45
`define PAB_IDX_DDAT 8'h46

// bank select field inside the bank selector
`define PAB_BANK_LSB 5
`define PAB_BANK_MSB 7
`define PAB_BANK_RST 8'h00

// vectors, all in bank 0
`define PAB_VEC_RESET 16'h0000
`define PAB_VEC_EXT 16'h0004
`define PAB_VEC_TMR0 16'h0008
`define PAB_VEC_TMR1 16'h000C
`define PAB_VEC_TMR2 16'h0010
`define PAB_VEC_TMR3 16'h0014
`define PAB_VEC_DAC 16'h0018

// table read of the last page fixes the high byte
`define PAB_LAST_PAGE 8'hFF

// stack depth and pointer width
`define PAB_STACK_DEPTH 8
`define PAB_SP_W 4
`define PAB_SP_FULL 4'h8

// sequencer commands (ctrl register bits 3:0)
`define PAB_CMD_W 4
`define PAB_CMD_NONE 4'h0
`define PAB_CMD_STEP 4'h1
`define PAB_CMD_JUMP 4'h2
`define PAB_CMD_CALL 4'h3
`define PAB_CMD_RET 4'h4
`define PAB_CMD_INTERRUPT_RETURN 4'h5
`define PAB_CMD_SKIP 4'h6
`define PAB_CMD_PCL 4'h7
`define PAB_CMD_TRDC 4'h8
`define PAB_CMD_TRDL 4'h9

`define PAB_NUM_IRQ 6
`endif

// File: rtl/pab_ret_stack.v
// program address banking: 8-level return stack of 16-bit addresses
// assumes push and pop are never asked in the same cycle
`timescale 1ns/10ps
`include "pab_regs.vh"

module pab_ret_stack (
  input wire sysClk,
  input wire resetN,
  input wire push,
  input wire pop,
  input wire [15:0] pushAddr,
  output wire [15:0] topAddr,
  output wire full,
  output wire empty
);
  reg [15:0] mem [0:`PAB_STACK_DEPTH-1];
  reg [`PAB_SP_W-1:0] sp_reg;
  integer i;

  assign full = (sp_reg == `PAB_SP_FULL);
  assign empty = (sp_reg == {`PAB_SP_W{1'b0}});
  assign topAddr = empty ? 16'h0000 : mem[sp_reg[2:0] - 3'h1];

  always @(posedge sysClk or negedge resetN) begin
    if (!resetN) begin
      sp_reg <= {`PAB_SP_W{1'b0}};
      for (i = 0; i < `PAB_STACK_DEPTH; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
    end else if (push && !full) begin
      mem[sp_reg[2:0]] <= pushAddr;
      sp_reg <= sp_reg + 4'h1;
    end else if (pop && !empty) begin
      sp_reg <= sp_reg - 4'h1;
    end
  end
endmodule

// File: tb/pab_rom_model.sv
// program rom model: 64K words, answers in the same cycle
// assumes romAddr comes straight from the address generator
`timescale 1ns/10ps
module pab_rom_model #(
  parameter logic [15:0] MASK = 16'hC33C
) (
  input logic [15:0] romAddr,
  output logic [15:0] romData
);
  // word derived from its own address so every location differs
  assign romData = romAddr ^ MASK;
endmodule

// File: tb/pab_core_checker.sv
// assertions on pab_core ports: vectors, table reads, pointer loads
// bound into each pab_core; sees its ports only
`timescale 1ns/10ps
`include "pab_regs.vh"
module pab_core_checker (
  input logic sys_clk,
  input logic reset_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  input logic [15:0] romAddr,
  input logic vectorTaken,
  input logic tableWrite
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic wrOk;
  logic [3:0] cmd;
  assign wrOk = psel && penable && pready && pwrite;
  assign cmd = wrOk && paddr[9:2] == `PAB_IDX_CTRL ? pwdata[3:0] : 4'h0;
  reset_fetch_a: assert property ($rose(reset_n) |-> romAddr == 16'h0000)
    else $error("fetch not at zero after reset");
  latch_ro_a: assert property (
    wrOk && paddr[9:2] == `PAB_IDX_TBHL |-> pslverr)
    else $error("latch write not refused");
  vec_bank0_a: assert property (vectorTaken |-> romAddr[15:13] == 3'h0)
    else $error("vector outside bank 0");
  vec_addr_a: assert property (vectorTaken |-> romAddr inside {
    16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014, 16'h0018})
    else $error("vector address not a service entry");
  tbl_two_a: assert property (
    cmd == `PAB_CMD_TRDC || cmd == `PAB_CMD_TRDL |=>
    !tableWrite [*2] ##1 tableWrite)
    else $error("table read not two cycles");
  tbl_last_a: assert property (
    cmd == `PAB_CMD_TRDL |-> ##2 romAddr[15:8] == 8'hFF)
    else $error("last page read off page");
  pcl_page_a: assert property (cmd == `PAB_CMD_PCL |=>
    romAddr[7:0] == $past(pwdata[15:8]) && romAddr[15:8] == $past(romAddr[15:8]))
    else $error("low byte load left page");
  skip_two_a: assert property (
    cmd == `PAB_CMD_SKIP |=> romAddr == $past(romAddr) + 16'h0002)
    else $error("skip not plus two");
endmodule

bind pab_core pab_core_checker chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .romAddr(romAddr),
  .vectorTaken(vectorTaken), .tableWrite(tableWrite));

// File: tb/tb.sv
// bench for pab_core: apb tasks and directed sequences
// assumes the rom model word is its address xor C33C
`timescale 1ns/10ps
`include "pab_regs.vh"
module tb;
  logic sys_clk = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rdData;
  logic pready, pslverr, rdErr, vectorTaken, tableWrite;
  logic [5:0] irqReq = 0;
  logic [5:0] irqEnable = 0;
  logic [15:0] romData, romAddr;
  logic [7:0] tableAddr, tableData;
  int errCount = 0;
  int nCompared = 0;
  logic [15:0] vecs [6] = '{`PAB_VEC_EXT, `PAB_VEC_TMR0, `PAB_VEC_TMR1,
    `PAB_VEC_TMR2, `PAB_VEC_TMR3, `PAB_VEC_DAC};
  pab_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqReq(irqReq),
    .irqEnable(irqEnable), .romData(romData), .romAddr(romAddr),
    .vectorTaken(vectorTaken), .tableWrite(tableWrite),
    .tableAddr(tableAddr), .tableData(tableData));
  pab_rom_model rom (.romAddr(romAddr), .romData(romData));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic testDone;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic hang;
    errCount++;
    testDone();
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) hang();
    rdData = prdata;
    rdErr = pslverr;
    psel <= 0;
    penable <= 0;
    // idle edge keeps commands clear of the dummy cycle
    @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [31:0] c);
    apb(1, `PAB_IDX_CTRL, c);
  endtask
  task automatic rd(input string what, input logic [7:0] idx,
      input logic [31:0] exp);
    apb(0, idx, 0);
    chk(what, exp, rdData);
  endtask
  task automatic waitFor(input bit tbl);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if ((tbl ? tableWrite : vectorTaken) === 1'b1) break;
    end
    if (n == 40) hang();
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1;
    chk("romAddr", `PAB_VEC_RESET, romAddr);
    apb(1, `PAB_IDX_PTRH, 32'h20);
    cmd(`PAB_CMD_JUMP);
    rd("start", `PAB_IDX_PTRL, 32'h0020);
    apb(1, `PAB_IDX_TPLO, 32'h34);
    apb(1, `PAB_IDX_TPHI, 32'h12);
    rd("tpLo", `PAB_IDX_TPLO, 32'h34);
    rd("tpHi", `PAB_IDX_TPHI, 32'h12);
    rd("unmapped", 8'h3F, 0);
    chk("slverr", 1, rdErr);
    apb(1, `PAB_IDX_DADR, 32'h55);
    cmd(`PAB_CMD_TRDC);
    waitFor(1);
    chk("tableAddr", 8'h55, tableAddr);
    chk("tableData", 8'h08, tableData);
    rd("lowByte", `PAB_IDX_DDAT, 32'h08);
    rd("latch", `PAB_IDX_TBHL, 32'hD1);
    apb(1, `PAB_IDX_TBHL, 32'h00);
    chk("slverr", 1, rdErr);
    rd("latch", `PAB_IDX_TBHL, 32'hD1);
    cmd(`PAB_CMD_TRDL);
    waitFor(1);
    rd("latch", `PAB_IDX_TBHL, 32'h3C);
    $display("test table done");
    apb(1, `PAB_IDX_PTRH, 32'h1ABC);
    for (int b = 0; b < 8; b++) begin
      apb(1, `PAB_IDX_BANK, {24'h0, b[2:0], 5'h0});
      rd("bank", `PAB_IDX_BANK, {24'h0, b[2:0], 5'h0});
      cmd(`PAB_CMD_JUMP);
      rd("pointer", `PAB_IDX_PTRL, {16'h0, b[2:0], 13'h1ABC});
    end
    apb(1, `PAB_IDX_BANK, 32'h00);
    rd("pointer", `PAB_IDX_PTRL, 32'hFABC);
    cmd(`PAB_CMD_SKIP);
    rd("pointer", `PAB_IDX_PTRL, 32'hFABE);
    cmd(32'h4D00 | `PAB_CMD_PCL);
    rd("pointer", `PAB_IDX_PTRL, 32'hFA4D);
    $display("test branches done");
    for (int i = 0; i < 6; i++) begin
      irqEnable <= 6'h01 << i;
      irqReq <= 6'h01 << i;
      waitFor(0);
      chk("vector", vecs[i], romAddr);
      irqReq <= 0;
      irqEnable <= 0;
      cmd(`PAB_CMD_INTERRUPT_RETURN);
      rd("return", `PAB_IDX_PTRL, 32'hFA4D);
    end
    irqEnable <= 6'h22;
    irqReq <= 6'h22;
    waitFor(0);
    chk("vector", `PAB_VEC_TMR0, romAddr);
    irqReq <= 0;
    irqEnable <= 6'h20;
    waitFor(0);
    chk("vector", `PAB_VEC_DAC, romAddr);
    irqEnable <= 0;
    cmd(`PAB_CMD_INTERRUPT_RETURN);
    cmd(`PAB_CMD_INTERRUPT_RETURN);
    rd("return", `PAB_IDX_PTRL, 32'hFA4D);
    repeat (8) cmd(`PAB_CMD_CALL);
    rd("stat", `PAB_IDX_STAT, 32'h08);
    irqEnable <= 6'h01;
    irqReq <= 6'h01;
    repeat (20) begin
      @(posedge sys_clk);
      chk("withheld", 0, vectorTaken);
    end
    rd("pending", `PAB_IDX_PEND, 32'h01);
    cmd(`PAB_CMD_RET);
    waitFor(0);
    chk("vector", `PAB_VEC_EXT, romAddr);
    $display("test interrupts done");
    testDone();
  end
endmodule
